/* rtl/can_mo_tx_filter.sv */
`timescale 1ns/100ps
module can_mo_tx_filter #(
    parameter int N  = can_mo_pkg::OBJ_N,
    parameter int PW = can_mo_pkg::PRI_W,
    parameter int IW = $clog2(N)
) (
    input  wire logic          clk_i,
    input  wire logic          rst_n_i,
    input  wire logic          cfg_wr_i,
    input  wire logic [IW-1:0] cfg_idx_i,
    input  wire logic          cfg_valid_i,
    input  wire logic          cfg_rx_permit_i,
    input  wire logic          cfg_tx_permit_i,
    input  wire logic          cfg_transmit_request_flag_i,
    input  wire logic [PW-1:0] cfg_pri_i,
    input  wire logic [IW-1:0] cfg_succ_i,
    input  wire logic          cfg_sdt_i,
    input  wire logic          cfg_foreign_remote_enable_i,
    input  wire logic [IW-1:0] cfg_cur_i,
    input  wire logic          alloc_i,
    input  wire logic          dealloc_i,
    input  wire logic [IW-1:0] list_idx_i,
    input  wire logic [IW-1:0] list_head_i,
    input  wire logic          remote_rx_i,
    input  wire logic [IW-1:0] remote_idx_i,
    input  wire logic          rx_done_i,
    input  wire logic [IW-1:0] rx_done_idx_i,
    input  wire logic          tx_busy_i,
    input  wire logic          tx_done_i,
    input  wire logic [IW-1:0] tx_done_idx_i,
    output logic               tx_start_o,
    output logic      [IW-1:0] tx_idx_o,
    output logic               list_err_o,
    output logic               walk_busy_o,
    output logic      [N-1:0]  obj_valid_o,
    output logic      [N-1:0]  obj_transmit_request_flag_o
);
    logic [N-1:0]          valid_q, valid_d, transmit_request_flag_q, transmit_request_flag_d, rxp_q, rxp_d, txp_q, txp_d;
    logic [N-1:0]          sdt_q, sdt_d, foreign_remote_enable_q, foreign_remote_enable_d, inlist_q, inlist_d;
    logic [N-1:0][PW-1:0]  pri_q, pri_d;
    logic [N-1:0][IW-1:0]  cur_q, cur_d;
    logic                  restart_q, restart_d;

    can_mo_pkg::walk_state_e state_q, state_d;
    logic [IW-1:0]         at_q, at_d, steps_q, steps_d, best_idx_q, best_idx_d;
    logic [IW-1:0]         win_idx_q, win_idx_d, rd_addr, rd_succ;
    logic [PW-1:0]         best_pri_q, best_pri_d, win_pri_q, win_pri_d;
    logic                  best_ok_q, best_ok_d, win_ok_q, win_ok_d, lerr_q, lerr_d;
    logic                  remote_acc, imm_ok, imm_win, walk_start, cand, tail;

    succ_ram #(.DEPTH(N), .AW(IW)) u_succ (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .we_i    (cfg_wr_i),
        .waddr_i (cfg_idx_i),
        .wdata_i (cfg_succ_i),
        .raddr_i (rd_addr),
        .rdata_o (rd_succ)
    );

    assign remote_acc = remote_rx_i && valid_q[remote_idx_i] && rxp_q[remote_idx_i];
    assign imm_ok     = remote_acc && txp_q[remote_idx_i]
                        && !(foreign_remote_enable_q[remote_idx_i] && cur_q[remote_idx_i] == remote_idx_i);
    assign imm_win    = imm_ok && (!win_ok_q || pri_q[remote_idx_i] < win_pri_q);
    assign walk_start = restart_q && state_q == can_mo_pkg::WALK_IDLE && |inlist_q;
    assign tx_start_o = win_ok_q && !tx_busy_i && !restart_q && !tx_done_i
                        && state_q == can_mo_pkg::WALK_IDLE;
    assign tx_idx_o    = win_idx_q;
    assign list_err_o  = lerr_q;
    assign walk_busy_o = state_q == can_mo_pkg::WALK_EVAL;
    assign obj_valid_o = valid_q;
    assign obj_transmit_request_flag_o  = transmit_request_flag_q;

    // Object flags; later assignments win, so hardware sets override clears
    always_comb begin
        valid_d   = valid_q;
        transmit_request_flag_d    = transmit_request_flag_q;
        rxp_d     = rxp_q;
        txp_d     = txp_q;
        sdt_d     = sdt_q;
        foreign_remote_enable_d   = foreign_remote_enable_q;
        inlist_d  = inlist_q;
        pri_d     = pri_q;
        cur_d     = cur_q;
        restart_d = restart_q;
        if (walk_start) begin
            restart_d = 1'b0;
        end
        if (tx_done_i) begin
            transmit_request_flag_d[tx_done_idx_i] = 1'b0;
            restart_d = 1'b1;
            if (sdt_q[tx_done_idx_i]) begin
                valid_d[tx_done_idx_i] = 1'b0;
            end
        end
        if (rx_done_i && valid_q[rx_done_idx_i] && rxp_q[rx_done_idx_i]
            && sdt_q[rx_done_idx_i]) begin
            valid_d[rx_done_idx_i] = 1'b0;
            restart_d = 1'b1;
        end
        if (cfg_wr_i) begin
            valid_d[cfg_idx_i] = cfg_valid_i;
            transmit_request_flag_d[cfg_idx_i]  = cfg_transmit_request_flag_i;
            rxp_d[cfg_idx_i]   = cfg_rx_permit_i;
            txp_d[cfg_idx_i]   = cfg_tx_permit_i;
            sdt_d[cfg_idx_i]   = cfg_sdt_i;
            foreign_remote_enable_d[cfg_idx_i] = cfg_foreign_remote_enable_i;
            pri_d[cfg_idx_i]   = cfg_pri_i;
            cur_d[cfg_idx_i]   = cfg_cur_i;
            // Any write may change the winner, so every write reruns the filter
            restart_d = 1'b1;
        end
        if (alloc_i || dealloc_i) begin
            // Membership change reruns the walk; a stale successor met on the rerun raises list_err_o
            inlist_d[list_idx_i] = alloc_i && !dealloc_i;
            restart_d = 1'b1;
        end
        if (remote_acc) begin
            transmit_request_flag_d[remote_idx_i] = 1'b1;
            if (!imm_win || state_q == can_mo_pkg::WALK_EVAL) begin
                restart_d = 1'b1;
            end
        end
    end

    // Filter walk, one object per cycle behind the registered pointer read
    always_comb begin
        state_d    = state_q;
        at_d       = at_q;
        steps_d    = steps_q;
        best_ok_d  = best_ok_q;
        best_idx_d = best_idx_q;
        best_pri_d = best_pri_q;
        win_ok_d   = win_ok_q;
        win_idx_d  = win_idx_q;
        win_pri_d  = win_pri_q;
        lerr_d     = 1'b0;
        rd_addr    = at_q;
        cand       = valid_q[at_q] && txp_q[at_q] && transmit_request_flag_q[at_q];
        tail       = rd_succ == at_q || steps_q == IW'(N - 1);
        if (tx_start_o) begin
            win_ok_d = 1'b0;
        end
        case (state_q)
            can_mo_pkg::WALK_IDLE: begin
                if (walk_start) begin
                    rd_addr   = list_head_i;
                    at_d      = list_head_i;
                    steps_d   = '0;
                    best_ok_d = 1'b0;
                    win_ok_d  = 1'b0;
                    state_d   = can_mo_pkg::WALK_EVAL;
                end
            end
            can_mo_pkg::WALK_EVAL: begin
                if (restart_q || inlist_q == '0) begin
                    // An emptied list ends the run quietly
                    state_d = can_mo_pkg::WALK_IDLE;
                end else if (!inlist_q[at_q]) begin
                    lerr_d  = 1'b1;
                    state_d = can_mo_pkg::WALK_IDLE;
                end else begin
                    if (cand && (!best_ok_q || pri_q[at_q] < best_pri_q)) begin
                        best_ok_d  = 1'b1;
                        best_idx_d = at_q;
                        best_pri_d = pri_q[at_q];
                    end
                    if (tail) begin
                        state_d   = can_mo_pkg::WALK_IDLE;
                        win_ok_d  = best_ok_d;
                        win_idx_d = best_idx_d;
                        win_pri_d = best_pri_d;
                    end else begin
                        rd_addr = rd_succ;
                        at_d    = rd_succ;
                        steps_d = steps_q + 1'b1;
                    end
                end
            end
            default: state_d = can_mo_pkg::WALK_IDLE;
        endcase
        if (imm_win) begin
            win_ok_d  = 1'b1;
            win_idx_d = remote_idx_i;
            win_pri_d = pri_q[remote_idx_i];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            valid_q    <= {N{can_mo_pkg::FLAG_RST}};
            transmit_request_flag_q     <= {N{can_mo_pkg::FLAG_RST}};
            rxp_q      <= {N{can_mo_pkg::FLAG_RST}};
            txp_q      <= {N{can_mo_pkg::FLAG_RST}};
            sdt_q      <= {N{can_mo_pkg::FLAG_RST}};
            foreign_remote_enable_q    <= {N{can_mo_pkg::FLAG_RST}};
            inlist_q   <= {N{can_mo_pkg::FLAG_RST}};
            pri_q      <= {N{PW'(can_mo_pkg::PRI_RST)}};
            cur_q      <= '0;
            restart_q  <= can_mo_pkg::FLAG_RST;
            state_q    <= can_mo_pkg::WALK_IDLE;
            at_q       <= '0;
            steps_q    <= '0;
            best_ok_q  <= 1'b0;
            best_idx_q <= '0;
            best_pri_q <= '0;
            win_ok_q   <= 1'b0;
            win_idx_q  <= '0;
            win_pri_q  <= '0;
            lerr_q     <= 1'b0;
        end else begin
            valid_q    <= valid_d;
            transmit_request_flag_q     <= transmit_request_flag_d;
            rxp_q      <= rxp_d;
            txp_q      <= txp_d;
            sdt_q      <= sdt_d;
            foreign_remote_enable_q    <= foreign_remote_enable_d;
            inlist_q   <= inlist_d;
            pri_q      <= pri_d;
            cur_q      <= cur_d;
            restart_q  <= restart_d;
            state_q    <= state_d;
            at_q       <= at_d;
            steps_q    <= steps_d;
            best_ok_q  <= best_ok_d;
            best_idx_q <= best_idx_d;
            best_pri_q <= best_pri_d;
            win_ok_q   <= win_ok_d;
            win_idx_q  <= win_idx_d;
            win_pri_q  <= win_pri_d;
            lerr_q     <= lerr_d;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_remote_sets_request: assert property (
        remote_acc && !(cfg_wr_i && cfg_idx_i == remote_idx_i)
        |=> transmit_request_flag_q[$past(remote_idx_i)])
        else $error("remote frame did not set transmit request");
    a_immediate_answer_win: assert property (
        imm_win |=> win_ok_q && win_idx_q == $past(remote_idx_i))
        else $error("immediate answer not prepared");
    a_lower_class_loses: assert property (
        imm_ok && win_ok_q && pri_q[remote_idx_i] >= win_pri_q |-> !imm_win)
        else $error("answer beat a better priority class");
    a_lost_answer_pending: assert property (
        remote_acc && !imm_win |=> restart_q ##[1:2] (walk_busy_o || !(|inlist_q)))
        else $error("pending answer not refiltered");
    a_foreign_remote_enable_blocks_answer: assert property (
        remote_acc && foreign_remote_enable_q[remote_idx_i] && cur_q[remote_idx_i] == remote_idx_i
        |-> !imm_win)
        else $error("immediate answer despite own fifo pointer");
    a_write_retriggers: assert property (
        cfg_wr_i && (cfg_transmit_request_flag_i || (valid_q[cfg_idx_i] && !cfg_valid_i)) |=> restart_q)
        else $error("write did not retrigger filtering");
    a_start_permitted: assert property (
        tx_start_o |-> valid_q[tx_idx_o] && txp_q[tx_idx_o])
        else $error("start of a non permitted object");
    a_empty_no_error: assert property (
        inlist_q == '0 |=> !list_err_o)
        else $error("list error on empty list");
    a_sdt_clears_valid: assert property (
        tx_done_i && sdt_q[tx_done_idx_i] && !(cfg_wr_i && cfg_idx_i == tx_done_idx_i)
        |=> !valid_q[$past(tx_done_idx_i)])
        else $error("single transfer did not clear valid");

    c_immediate_answer: cover property (imm_win ##[1:4] tx_start_o);
    c_walk_start: cover property (walk_start ##[2:20] tx_start_o);
    c_list_error: cover property (list_err_o);
endmodule

/* rtl/succ_ram.sv */
`timescale 1ns/100ps
module succ_ram #(
    parameter int DEPTH = 8,
    parameter int AW    = 3
) (
    input  wire logic          clk_i,
    input  wire logic          rst_n_i,
    input  wire logic          we_i,
    input  wire logic [AW-1:0] waddr_i,
    input  wire logic [AW-1:0] wdata_i,
    input  wire logic [AW-1:0] raddr_i,
    output logic      [AW-1:0] rdata_o
);
    logic [AW-1:0] mem [DEPTH];

    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
    end

    // Write-through keeps a pointer just written visible to a walk in flight
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= '0;
        end else if (we_i && waddr_i == raddr_i) begin
            rdata_o <= wdata_i;
        end else begin
            rdata_o <= mem[raddr_i];
        end
    end
endmodule

/* shared/can_mo_pkg.sv */
package can_mo_pkg;
    localparam int          OBJ_N    = 8;
    localparam int          PRI_W    = 2;
    localparam logic        FLAG_RST = 1'b0;
    localparam logic [1:0]  PRI_RST  = 2'h3;

    typedef enum logic [0:0] {
        WALK_IDLE = 1'b0,
        WALK_EVAL = 1'b1
    } walk_state_e;
endpackage

/* tb/can_mo_tx_filter_test.sv */
`timescale 1ns/100ps
module can_mo_tx_filter_test;
    localparam int IW = $clog2(can_mo_pkg::OBJ_N);
    logic          clk_i, rst_n_i, cfg_wr_i, cfg_valid_i, cfg_rx_permit_i, cfg_tx_permit_i;
    logic          cfg_transmit_request_flag_i, cfg_sdt_i, cfg_foreign_remote_enable_i, alloc_i, dealloc_i, remote_rx_i;
    logic          rx_done_i, tx_busy_i, tx_done_i, tx_start_o, list_err_o, walk_busy_o;
    logic [IW-1:0] cfg_idx_i, cfg_succ_i, cfg_cur_i, list_idx_i, list_head_i, remote_idx_i;
    logic [IW-1:0] rx_done_idx_i, tx_done_idx_i, tx_idx_o;
    logic [1:0]    cfg_pri_i;
    logic [7:0]    obj_valid_o, obj_transmit_request_flag_o, frame_len;
    int            n_errors, tests_run, n_lerr, k;

    can_mo_tx_filter i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .cfg_wr_i(cfg_wr_i),
        .cfg_idx_i(cfg_idx_i), .cfg_valid_i(cfg_valid_i), .cfg_rx_permit_i(cfg_rx_permit_i),
        .cfg_tx_permit_i(cfg_tx_permit_i), .cfg_transmit_request_flag_i(cfg_transmit_request_flag_i), .cfg_pri_i(cfg_pri_i),
        .cfg_succ_i(cfg_succ_i), .cfg_sdt_i(cfg_sdt_i), .cfg_foreign_remote_enable_i(cfg_foreign_remote_enable_i),
        .cfg_cur_i(cfg_cur_i), .alloc_i(alloc_i), .dealloc_i(dealloc_i), .list_idx_i(list_idx_i),
        .list_head_i(list_head_i), .remote_rx_i(remote_rx_i), .remote_idx_i(remote_idx_i),
        .rx_done_i(rx_done_i), .rx_done_idx_i(rx_done_idx_i), .tx_busy_i(tx_busy_i),
        .tx_done_i(tx_done_i), .tx_done_idx_i(tx_done_idx_i), .tx_start_o(tx_start_o),
        .tx_idx_o(tx_idx_o), .list_err_o(list_err_o), .walk_busy_o(walk_busy_o),
        .obj_valid_o(obj_valid_o), .obj_transmit_request_flag_o(obj_transmit_request_flag_o));

    can_node_model #(.IW(IW)) i_node (.clk_i(clk_i), .rst_n_i(rst_n_i), .tx_start_i(tx_start_o),
        .tx_idx_i(tx_idx_o), .frame_len_i(frame_len), .tx_busy_o(tx_busy_i),
        .tx_done_o(tx_done_i), .tx_done_idx_o(tx_done_idx_i));

    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        if (list_err_o === 1'b1) begin
            n_lerr++;
        end
    end

    task automatic check(input string nm, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
        end
    endtask

    task automatic conclude();
        $display("checks %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Flags are {valid, rx permit, tx permit, transmit_request_flag, single transfer, foreign_remote_enable, cur on self}
    task automatic cfg(input logic [IW-1:0] i, input logic [6:0] f, input logic [1:0] p);
        @(negedge clk_i);
        cfg_wr_i = 1'b1;
        cfg_idx_i = i;
        {cfg_valid_i, cfg_rx_permit_i, cfg_tx_permit_i, cfg_transmit_request_flag_i, cfg_sdt_i, cfg_foreign_remote_enable_i} = f[6:1];
        cfg_pri_i = p;
        cfg_succ_i = (i < 3) ? i + 1'b1 : i;
        cfg_cur_i = f[0] ? i : ~i;
        @(negedge clk_i);
        cfg_wr_i = 1'b0;
    endtask

    // Kind 0 alloc, 1 dealloc, 2 remote frame, 3 reception done
    task automatic pulse(input int kind, input logic [IW-1:0] i);
        @(negedge clk_i);
        list_idx_i = i;
        remote_idx_i = i;
        rx_done_idx_i = i;
        alloc_i = (kind == 0);
        dealloc_i = (kind == 1);
        remote_rx_i = (kind == 2);
        rx_done_i = (kind == 3);
        @(negedge clk_i);
        {alloc_i, dealloc_i, remote_rx_i, rx_done_i} = 4'h0;
    endtask

    task automatic wait_tx(input logic [IW-1:0] exp);
        int n;
        n = 0;
        while (tx_done_i !== 1'b1 && n < 400) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        check("tx_done", 8'h01, {7'h00, tx_done_i});
        check("tx_done_idx", {5'h00, exp}, {5'h00, tx_done_idx_i});
        @(posedge clk_i);
        @(negedge clk_i);
    endtask

    task automatic setup(input logic [7:0] pris);
        for (int i = 0; i < 4; i++) begin
            cfg(i[IW-1:0], 7'h70, pris[2*i +: 2]);
        end
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        n_errors++;
        $display("watchdog expired");
        conclude();
    end

    initial begin
        rst_n_i = 1'b0;
        {cfg_wr_i, cfg_valid_i, cfg_rx_permit_i, cfg_tx_permit_i, cfg_transmit_request_flag_i, cfg_sdt_i} = '0;
        {cfg_foreign_remote_enable_i, alloc_i, dealloc_i, remote_rx_i, rx_done_i} = '0;
        {cfg_idx_i, cfg_succ_i, cfg_cur_i, list_idx_i, list_head_i} = '0;
        {remote_idx_i, rx_done_idx_i, cfg_pri_i} = '0;
        frame_len = 8'h01;
        n_errors = 0;
        tests_run = 0;
        n_lerr = 0;
        repeat (20) @(negedge clk_i);
        check("reset_valid", 8'h00, obj_valid_o);
        check("reset_transmit_request_flag", 8'h00, obj_transmit_request_flag_o);
        rst_n_i = 1'b1;
        $display("test reset done");
        setup(8'h1b);
        for (int i = 0; i < 4; i++) begin
            pulse(0, i[IW-1:0]);
        end
        cfg(1, 7'h78, 2);
        cfg(2, 7'h68, 1);
        cfg(3, 7'h78, 0);
        wait_tx(3);
        wait_tx(1);
        repeat (60) @(negedge clk_i);
        check("held_transmit_request_flag", 8'h04, obj_transmit_request_flag_o & 8'h04);
        check("held_valid", 8'h0f, obj_valid_o);
        cfg(2, 7'h78, 1);
        wait_tx(2);
        $display("test filtering done");
        cfg(0, 7'h7c, 3);
        wait_tx(0);
        check("sdt_tx_valid", 8'h0e, obj_valid_o);
        cfg(1, 7'h74, 2);
        pulse(3, 1);
        repeat (2) @(negedge clk_i);
        check("sdt_rx_valid", 8'h0c, obj_valid_o);
        $display("test single transfer done");
        setup(8'h1b);
        cfg(3, 7'h78, 0);
        cfg(2, 7'h78, 1);
        cfg(3, 7'h38, 0);
        wait_tx(2);
        check("cleared_valid", 8'h07, obj_valid_o);
        $display("test clear valid done");
        setup(8'h1b);
        cfg(7, 7'h78, 0);
        k = 0;
        while (walk_busy_o !== 1'b1 && k < 4) begin
            @(negedge clk_i);
            k++;
        end
        check("walk_busy", 8'h01, {7'h00, walk_busy_o});
        repeat (40) @(negedge clk_i);
        check("unalloc_transmit_request_flag", 8'h80, obj_transmit_request_flag_o & 8'h80);
        $display("test retrigger done");
        // Long frames keep the node busy so the remote answers meet a walk in flight
        frame_len = 8'h1e;
        cfg(2, 7'h78, 1);
        repeat (10) @(negedge clk_i);
        cfg(1, 7'h78, 2);
        pulse(2, 3);
        check("remote_transmit_request_flag", 8'h08, obj_transmit_request_flag_o & 8'h08);
        wait_tx(2);
        wait_tx(3);
        wait_tx(1);
        cfg(2, 7'h78, 1);
        repeat (10) @(negedge clk_i);
        cfg(1, 7'h78, 2);
        pulse(2, 0);
        wait_tx(2);
        wait_tx(1);
        wait_tx(0);
        cfg(0, 7'h73, 3);
        pulse(2, 0);
        check("foreign_remote_enable_transmit_request_flag", 8'h01, obj_transmit_request_flag_o & 8'h01);
        wait_tx(0);
        $display("test remote answer done");
        pulse(1, 2);
        repeat (10) @(negedge clk_i);
        check("list_err_seen", 8'h01, n_lerr[7:0]);
        pulse(0, 2);
        repeat (10) @(negedge clk_i);
        n_lerr = 0;
        for (int i = 3; i >= 0; i--) begin
            pulse(1, i[IW-1:0]);
        end
        repeat (10) @(negedge clk_i);
        check("list_err", 8'h00, n_lerr[7:0]);
        $display("test dealloc done");
        conclude();
    end
endmodule

/* tb/can_node_model.sv */
`timescale 1ns/100ps
// Far-side node: takes the offered object, stays busy for frame_len_i cycles, then reports done
module can_node_model #(
    parameter int IW = 3
) (
    input  wire logic          clk_i,
    input  wire logic          rst_n_i,
    input  wire logic          tx_start_i,
    input  wire logic [IW-1:0] tx_idx_i,
    input  wire logic [7:0]    frame_len_i,
    output logic               tx_busy_o,
    output logic               tx_done_o,
    output logic      [IW-1:0] tx_done_idx_o
);
    logic [7:0]    cnt_q;
    logic [IW-1:0] cur_q;

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= 8'h00;
            cur_q <= '0;
            tx_busy_o <= 1'b0;
            tx_done_o <= 1'b0;
            tx_done_idx_o <= '0;
        end else begin
            tx_done_o <= 1'b0;
            // Index toggles outside the done pulse so a stale value never looks valid
            tx_done_idx_o <= ~tx_done_idx_o;
            if (tx_busy_o) begin
                cnt_q <= cnt_q - 8'h01;
                if (cnt_q <= 8'h01) begin
                    tx_busy_o <= 1'b0;
                    tx_done_o <= 1'b1;
                    tx_done_idx_o <= cur_q;
                end
            end else if (tx_start_i) begin
                tx_busy_o <= 1'b1;
                cnt_q <= frame_len_i;
                cur_q <= tx_idx_i;
            end
        end
    end
endmodule
